// ===== rtl/ets_elapsed_time.sv
// Elapsed-time counter with triggers and pulse-per-second sync
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ets_elapsed_time
  import ets_pkg::*;
#(
  parameter int NUM_TRIG = 8,
  parameter int unsigned CLK_HZ = CLK_FREQ_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Pulse lines
  input wire logic extTimePulseIn,
  input wire logic sharedPulseLineIn,
  output logic sharedPulseLineOut,
  output logic sharedPulseLineOe,
  // Triggers
  input wire logic [NUM_TRIG-1:0] trigIn,
  // Event pulses
  output logic ppsArrived,
  output logic ppsLost,
  output logic ppsFound
);

  function automatic logic [23:0] stamp24(input ets_time_t t);
    stamp24 = {t.sec[7:0], t.sub};
  endfunction

  ets_time_t now;
  ets_pps_cfg_t cfg;
  ets_mode_t mode;
  logic [31:0] fracAcc;
  logic [31:0] accSum;
  logic subTick;
  logic [31:0] adjSec;
  logic [15:0] snapSub;
  logic [7:0] trigPol;
  logic [7:0] trigEn;
  logic [NUM_TRIG-1:0] trigD;
  logic [NUM_TRIG-1:0] trigHit;
  logic [NUM_TRIG-1:0] trigFlags;
  logic [23:0] trigSamp [NUM_TRIG];
  logic [23:0] ppsSamp;
  logic [2:0] ppsFlags;
  logic [15:0] pulseCnt;
  logic ppsInD;
  logic havePrev;
  logic [16:0] gap;
  logic wrSec, wrSub, wrCtrl, wrEvent;
  logic ppsIn, ppsEdge, ext, inWindow, late;
  logic accept, lostNow, foundNow, secTick, emit;
  logic [16:0] winLo, winHi;
  logic [31:0] evWord;
  logic [2:0] trigIdx;

  assign wrSec = regWr && regAddr == REG_SEC;
  assign wrSub = regWr && regAddr == REG_SUB;
  assign wrCtrl = regWr && regAddr == REG_CTRL;
  assign wrEvent = regWr && regAddr == REG_EVENT;

  // Fractional accumulator gives an exact 65536 Hz average tick
  assign accSum = fracAcc + SUB_RATE;
  assign subTick = accSum >= CLK_HZ;

  always_comb begin
    case ({cfg.src, cfg.outEn})
      2'b10: mode = MODE_FREE;
      2'b11: mode = MODE_MASTER;
      2'b01: mode = MODE_MSYNC;
      2'b00: mode = MODE_SLAVE;
      default: mode = MODE_FREE;
    endcase
  end

  // Master modes sample the external input; otherwise the shared line
  assign ppsIn = cfg.outEn ? extTimePulseIn : sharedPulseLineIn;
  assign ppsEdge = ppsIn && !ppsInD;
  assign ext = cfg.src == SRC_EXTERNAL;
  assign winLo = NOMINAL_GAP - {1'b0, cfg.thresh};
  assign winHi = NOMINAL_GAP + 17'h1 + {1'b0, cfg.thresh};
  assign inWindow = gap >= winLo && gap <= winHi;
  // Gap saturates at the top, so maximum threshold never times out
  assign late = gap > winHi;
  assign accept = ppsEdge && ext && (inWindow || !havePrev);
  assign lostNow = ext && havePrev && ((ppsEdge && !inWindow) || (!ppsEdge && late));
  assign foundNow = ppsEdge && !ext;
  assign secTick = subTick && now.sub == SUB_MAX && !wrSub && !accept;
  assign emit = secTick && (mode == MODE_MASTER || mode == MODE_MSYNC);

  always_ff @(posedge clk) begin
    if (srst) begin
      now <= '0;
      fracAcc <= '0;
    end else if (wrSub) begin
      // Full-width add lets subsecond borrow reach the seconds
      // Tick still counts so an adjust never loses a subsecond
      now <= now + {adjSec, 16'h0000} + {{32{regWdata[15]}}, regWdata[15:0]}
        + 48'(subTick);
      fracAcc <= subTick ? accSum - CLK_HZ : accSum;
    end else if (accept) begin
      now.sub <= '0;
      fracAcc <= '0;
      if (now.sub >= HALF_SEC_SUB) begin
        now.sec <= now.sec + 32'h1;
      end
    end else begin
      fracAcc <= subTick ? accSum - CLK_HZ : accSum;
      if (subTick) begin
        now <= now + 48'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      adjSec <= '0;
      snapSub <= '0;
    end else begin
      if (wrSec) begin
        adjSec <= regWdata;
      end
      if (regRd && regAddr == REG_SEC) begin
        snapSub <= now.sub;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= '{src: SRC_RST, outEn: OE_RST, thresh: THRESH_RST};
      trigPol <= TRIG_RST;
      trigEn <= TRIG_RST;
    end else begin
      if (wrCtrl) begin
        cfg.src <= regWdata[CTRL_SRC];
        cfg.outEn <= regWdata[CTRL_OE];
      end
      // Hardware fallback beats a software write in the same cycle
      if (lostNow) begin
        cfg.src <= SRC_INTERNAL;
      end
      if (regWr && regAddr == REG_THRESH) begin
        cfg.thresh <= regWdata[15:0];
      end
      if (regWr && regAddr == REG_TRIG_POL) begin
        trigPol <= regWdata[7:0];
      end
      if (regWr && regAddr == REG_TRIG_EN) begin
        trigEn <= regWdata[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ppsInD <= 1'b0;
      havePrev <= 1'b0;
      gap <= GAP_SAT;
      ppsSamp <= '0;
    end else begin
      ppsInD <= ppsIn;
      if (ppsEdge) begin
        gap <= '0;
        havePrev <= 1'b1;
      end else if (subTick && gap != GAP_SAT) begin
        gap <= gap + 17'h1;
      end
      // Reselecting restarts the window from the next pulse
      if (wrCtrl) begin
        havePrev <= 1'b0;
      end
      if (accept) begin
        ppsSamp <= stamp24(now);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pulseCnt <= '0;
      sharedPulseLineOut <= 1'b0;
    end else if (!cfg.outEn) begin
      pulseCnt <= '0;
      sharedPulseLineOut <= 1'b0;
    end else if (emit) begin
      pulseCnt <= PULSE_WIDTH_SUB;
      sharedPulseLineOut <= 1'b1;
    end else if (subTick && pulseCnt != 16'h0) begin
      pulseCnt <= pulseCnt - 16'h1;
      sharedPulseLineOut <= pulseCnt != 16'h1;
    end
  end

  assign sharedPulseLineOe = cfg.outEn;

  always_ff @(posedge clk) begin
    if (srst) begin
      ppsFlags <= '0;
      ppsArrived <= 1'b0;
      ppsLost <= 1'b0;
      ppsFound <= 1'b0;
    end else begin
      ppsArrived <= accept;
      ppsLost <= lostNow;
      ppsFound <= foundNow;
      // Set wins over a write-one clear
      ppsFlags <= (ppsFlags & ~({3{wrEvent}} & regWdata[2:0]))
        | {foundNow, lostNow, accept};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trigD <= '0;
    end else begin
      trigD <= trigIn;
    end
  end

  for (genvar i = 0; i < NUM_TRIG; i++) begin : g_trig
    assign trigHit[i] = trigEn[i] && (trigPol[i] ? (trigD[i] && !trigIn[i])
      : (!trigD[i] && trigIn[i]));
    a_trig_sample: assert property (@(posedge clk) disable iff (srst)
      trigHit[i] |=> trigSamp[i] == {$past(now.sec[7:0]), $past(now.sub)})
      else $error("trigger sample wrong");

    a_trig_flag: assert property (@(posedge clk) disable iff (srst)
      trigHit[i] |=> trigFlags[i])
      else $error("trigger event not flagged");
  end

  // One process for all triggers keeps a single driver per array
  always_ff @(posedge clk) begin
    if (srst) begin
      trigSamp <= '{default: '0};
      trigFlags <= '0;
    end else begin
      for (int i = 0; i < NUM_TRIG; i++) begin
        if (trigHit[i]) begin
          trigSamp[i] <= stamp24(now);
        end
        // Set wins over a write-one clear
        trigFlags[i] <= trigHit[i] || (trigFlags[i]
          && !(wrEvent && regWdata[EV_TRIG_LSB + i]));
      end
    end
  end

  always_comb begin
    evWord = '0;
    evWord[EV_ARRIVED] = ppsFlags[0];
    evWord[EV_LOST] = ppsFlags[1];
    evWord[EV_FOUND] = ppsFlags[2];
    evWord[EV_TRIG_LSB +: NUM_TRIG] = trigFlags;
  end

  assign trigIdx = regAddr[4:2];

  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regRd) begin
      case (regAddr)
        REG_SEC: regRdata <= now.sec;
        REG_SUB: regRdata <= {16'h0000, snapSub};
        REG_CTRL: regRdata <= {24'h0, mode, 2'b00, cfg.outEn, cfg.src};
        REG_THRESH: regRdata <= {16'h0000, cfg.thresh};
        REG_TRIG_POL: regRdata <= {24'h0, trigPol};
        REG_TRIG_EN: regRdata <= {24'h0, trigEn};
        REG_EVENT: regRdata <= evWord;
        REG_PPS_SAMP: regRdata <= {8'h00, ppsSamp};
        default: begin
          if (regAddr[7:5] == REG_TRIG_SAMP_HI && 32'(trigIdx) < NUM_TRIG) begin
            regRdata <= {8'h00, trigSamp[trigIdx]};
          end else begin
            regRdata <= '0;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_time_read;
    regRd && regAddr == REG_SEC ##1 regRd && regAddr == REG_SUB;
  endsequence

  sequence s_sec_emit;
    emit && cfg.outEn;
  endsequence

  a_carry_wrap: assert property (secTick |=> now.sub == 16'h0
    && now.sec == $past(now.sec) + 32'h1)
    else $error("carry not taken");

  a_read_atomic: assert property (s_time_read
    |=> regRdata[15:0] == $past(now.sub, 2))
    else $error("torn time read");

  a_adjust_add: assert property (wrSub |=> now == $past(now)
    + {$past(adjSec), 16'h0} + {{32{$past(regWdata[15])}}, $past(regWdata[15:0])}
    + 48'($past(subTick)))
    else $error("adjust not added");

  a_lost_revert: assert property (lostNow
    |=> cfg.src == SRC_INTERNAL && ppsLost)
    else $error("no fallback on loss");

  a_found_internal: assert property (ppsEdge && !ext
    |=> ppsFound && !ppsArrived)
    else $error("found not flagged");

  a_free_ignore: assert property (mode == MODE_FREE
    |=> !ppsArrived && !ppsLost)
    else $error("free mode used a pulse");

  a_sync_align: assert property (accept |=> now.sub == 16'h0 && ppsArrived
    && ppsSamp == {$past(now.sec[7:0]), $past(now.sub)})
    else $error("pulse not aligned");

  a_master_pulse: assert property (s_sec_emit |=> sharedPulseLineOut
    && sharedPulseLineOe ##1 sharedPulseLineOut)
    else $error("master pulse missing");

  a_window_lost: assert property (ppsEdge && ext && havePrev && gap < winLo
    |=> cfg.src == SRC_INTERNAL)
    else $error("early pulse accepted");

  a_slave_fallback: assert property (lostNow && !wrCtrl && mode == MODE_SLAVE
    |=> mode == MODE_FREE)
    else $error("slave did not fall back");

  a_msync_fallback: assert property (lostNow && !wrCtrl && mode == MODE_MSYNC
    |=> mode == MODE_MASTER)
    else $error("sync master did not fall back");

  // Only software may bring the external source back
  a_no_auto_sync: assert property (!ext && !wrCtrl |=> !ext)
    else $error("source went external by itself");

  a_input_quiet: assert property (!cfg.outEn |=> !sharedPulseLineOut)
    else $error("shared line driven as input");

  a_window_accept: assert property (ppsEdge && ext && havePrev && inWindow
    |=> ppsArrived)
    else $error("in-window pulse refused");

  // Widest window must never report a loss
  a_max_thresh: assert property (cfg.thresh == SUB_MAX |-> !lostNow)
    else $error("loss at maximum threshold");

  a_event_split: assert property (ppsArrived |-> !ppsLost && !ppsFound)
    else $error("pulse events overlap");

  a_free_count: assert property (mode == MODE_FREE && subTick && !wrSub
    |=> now == $past(now) + 48'h1)
    else $error("free count disturbed");

  a_pulse_hold: assert property (sharedPulseLineOut |-> pulseCnt != 16'h0)
    else $error("pulse without width count");
endmodule
`default_nettype wire

// ===== rtl/ets_pkg.sv
// Elapsed-time counter constants, register map and carrier types
// How it works
// - Time is seconds plus 1/65536-second subseconds
// - Enabled trigger edge captures time sample
// - Sample holds seconds low byte, then subseconds
// - Accepted incoming pulse also captures sample
// - External time pulse is input only
// - Shared line driven only when output enabled
// - Pulse outside window is declared lost
// - After loss, software must reselect external
// - Separate arrived, lost and found events
// - Free-running ignores both lines for timing
// - Master emits shared pulse each second
// - Master-sync aligns to external, falls back
// - Slave aligns to shared line, falls back
// - Time read is one atomic snapshot
// - Time is four seconds bytes, two subsecond
// - Time write adds signed differences
// - Source select: 0 external, 1 internal default
// - Output enable: 0 shared input, 1 drive
// - 16-bit threshold in subseconds, reset 0
// - Polarity bit per trigger, 1 falling
// - Eight-bit trigger enable, reset all off
// - Trigger count is a build parameter
// - Window is 65535-th to 65536+th; max disables
// - Loss on external reverts source to internal
// - Internal source still flags found pulses
package ets_pkg;
  localparam int unsigned CLK_FREQ_HZ = 250000000;
  localparam logic [31:0] SUB_RATE = 32'h0001_0000;
  localparam logic [15:0] SUB_MAX = 16'hFFFF;
  localparam logic [15:0] HALF_SEC_SUB = 16'h8000;
  localparam logic [15:0] PULSE_WIDTH_SUB = 16'h0100;
  localparam logic [16:0] NOMINAL_GAP = 17'h0FFFF;
  localparam logic [16:0] GAP_SAT = 17'h1FFFF;
  localparam logic [7:0] REG_SEC = 8'h00;
  localparam logic [7:0] REG_SUB = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_THRESH = 8'h0C;
  localparam logic [7:0] REG_TRIG_POL = 8'h10;
  localparam logic [7:0] REG_TRIG_EN = 8'h14;
  localparam logic [7:0] REG_EVENT = 8'h18;
  localparam logic [7:0] REG_PPS_SAMP = 8'h1C;
  localparam logic [2:0] REG_TRIG_SAMP_HI = 3'h1;
  localparam int CTRL_SRC = 0;
  localparam int CTRL_OE = 1;
  localparam int EV_ARRIVED = 0;
  localparam int EV_LOST = 1;
  localparam int EV_FOUND = 2;
  localparam int EV_TRIG_LSB = 8;
  localparam logic SRC_EXTERNAL = 1'b0;
  localparam logic SRC_INTERNAL = 1'b1;
  localparam logic SRC_RST = SRC_INTERNAL;
  localparam logic OE_RST = 1'b0;
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] TRIG_RST = 8'h00;

  typedef enum logic [3:0] {
    MODE_FREE = 4'h1,
    MODE_MASTER = 4'h2,
    MODE_MSYNC = 4'h4,
    MODE_SLAVE = 4'h8
  } ets_mode_t;

  typedef struct packed {
    logic [31:0] sec;
    logic [15:0] sub;
  } ets_time_t;

  typedef struct packed {
    logic src;
    logic outEn;
    logic [15:0] thresh;
  } ets_pps_cfg_t;
endpackage

// ===== verif/elapsed_time_pps_sync_tb_top.sv
// Self-checking bench for the elapsed-time counter
`timescale 1ns/100ps
`default_nettype none
module elapsed_time_pps_sync_tb_top;
  import ets_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [7:0] trigIn = 8'h00;
  logic [1:0] lineSel = 2'h0;
  logic [17:0] gap = 18'h0_0000;
  logic extP, shDrv, shOe, shOut, shDevOe, arr, lost, found;
  wire logic shWire;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0, stamp = 0, stampRef = 0, arrN = 0, lostN = 0, foundN = 0, hiN = 0, n0 = 0;
  logic [47:0] tRef, t, te;
  logic [31:0] lfsr = 32'h0000_7B4C;
  logic [31:0] d, dsec;
  logic [15:0] dsub;
  logic [7:0] pol;
  int ts;
  logic [7:0] ad [8] = '{REG_CTRL, REG_THRESH, REG_TRIG_POL, REG_TRIG_EN, REG_EVENT,
    REG_PPS_SAMP, 8'h20, 8'hFC};

  assign shWire = shDevOe ? shOut : (shOe ? shDrv : 1'b0);

  ets_elapsed_time #(.NUM_TRIG(8), .CLK_HZ(65536)) i_dut (.clk(clk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .extTimePulseIn(extP), .sharedPulseLineIn(shWire),
    .sharedPulseLineOut(shOut), .sharedPulseLineOe(shDevOe), .trigIn(trigIn),
    .ppsArrived(arr), .ppsLost(lost), .ppsFound(found));
  ets_pulse_gen i_gen (.clk(clk), .lineSel(lineSel), .gap(gap), .extPulse(extP),
    .shDrv(shDrv), .shOe(shOe));

  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    arrN <= arrN + int'(arr);
    lostN <= lostN + int'(lost);
    foundN <= foundN + int'(found);
    hiN <= hiN + int'(shOut);
  end

  function automatic logic [31:0] step(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [47:0] now(int c);
    return tRef + 48'(c - stampRef);
  endfunction
  task automatic chk(string what, logic [47:0] exp, logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Capture points carry a few cycles of pipeline slack
  task automatic near(string what, logic [23:0] exp, logic [23:0] got, int tol);
    logic [23:0] diff;
    diff = got - exp;
    comparisons++;
    if ((diff <= 24'(tol)) !== 1'b1) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitN(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
    stamp = cyc;
  endtask
  // Back-to-back reads, seconds then the latched subseconds
  task automatic rdTime();
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= REG_SEC;
    @(posedge clk);
    regAddr <= REG_SUB;
    #1;
    t[47:16] = regRdata;
    stamp = cyc;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    t[15:0] = regRdata[15:0];
  endtask
  task automatic pulses(logic [1:0] sel, logic [17:0] g, int n);
    @(posedge clk);
    lineSel <= sel;
    gap <= g;
    #1 te = now(cyc);
    waitN(n);
    lineSel <= 2'h0;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    waitN(20000);
    num_errors++;
    stop_test();
  end

  initial begin
    waitN(4);
    srst <= 1'b0;
    wr(8'hFC, 32'hFFFF_FFFF);
    foreach (ad[i]) begin
      rd(ad[i]);
      chk("reset value", (i == 0) ? 48'h11 : 48'h0, 48'(d));
    end
    $display("test reset done");
    rdTime();
    tRef = t;
    stampRef = stamp;
    for (int i = 0; i < 4; i++) begin
      lfsr = step(lfsr);
      rdTime();
      chk("time", now(stamp), t);
      dsec = (i == 0) ? 32'h0000_0003 : lfsr;
      dsub = (i == 0) ? 16'hFFC0 - t[15:0] : lfsr[31:16];
      wr(REG_SEC, dsec);
      wr(REG_SUB, {16'h0000, dsub});
      tRef = tRef + {dsec, 16'h0000} + {{32{dsub[15]}}, dsub};
      waitN(100);
    end
    $display("test time done");
    pol = lfsr[7:0];
    trigIn <= pol;
    wr(REG_TRIG_POL, {24'h00_0000, pol});
    wr(REG_TRIG_EN, 32'h0000_00FE);
    wr(REG_EVENT, 32'hFFFF_FFFF);
    rd(REG_TRIG_POL);
    chk("polarity", 48'(pol), 48'(d));
    rdTime();
    chk("time", now(stamp), t);
    @(posedge clk);
    trigIn <= ~pol;
    #1 ts = cyc;
    te = now(ts);
    waitN(4);
    rd(REG_EVENT);
    chk("trigger events", 48'h0000_FE00, 48'(d));
    for (int n = 0; n < 8; n++) begin
      rd(8'h20 + 8'(4 * n));
      if (n == 0)
        chk("disabled sample", 48'h0, 48'(d));
      else
        near("trigger sample", te[23:0], d[23:0], 4);
    end
    wr(REG_EVENT, 32'hFFFF_FFFF);
    trigIn <= pol;
    waitN(4);
    rd(REG_EVENT);
    chk("inactive edge", 48'h0, 48'(d));
    $display("test triggers done");
    wr(REG_THRESH, 32'h0000_FF00);
    wr(REG_CTRL, 32'h0000_0000);
    rd(REG_CTRL);
    chk("slave mode", 48'h80, 48'(d));
    pulses(2'h2, 18'h0_010F, 408);
    chk("arrivals", 48'h2, 48'(arrN));
    rd(REG_PPS_SAMP);
    te[47:16] = te[47:16] + 32'(te[15]);
    near("pulse sample", {te[23:16], 16'h010C}, d[23:0], 6);
    pulses(2'h2, 18'h0_00DF, 768);
    chk("lost", 48'h1, 48'(lostN));
    chk("no resync", 48'h2, 48'(arrN));
    chk("found", 48'h1, 48'(foundN >= 2));
    rd(REG_CTRL);
    chk("fallback free", 48'h11, 48'(d));
    $display("test slave done");
    wr(REG_CTRL, 32'h0000_0002);
    rd(REG_CTRL);
    chk("sync master mode", 48'h42, 48'(d));
    chk("drive enable", 48'h1, 48'(shDevOe));
    pulses(2'h1, 18'h0_010F, 408);
    chk("arrivals", 48'h4, 48'(arrN));
    rdTime();
    wr(REG_SEC, 32'h0000_0000);
    wr(REG_SUB, {16'h0000, 16'hFFC0 - t[15:0]});
    n0 = hiN;
    waitN(512);
    near("pulse width", 24'h00_00FE, 24'(hiN - n0), 4);
    pulses(2'h1, 18'h0_00DF, 512);
    chk("arrivals", 48'h5, 48'(arrN));
    chk("lost", 48'h2, 48'(lostN));
    rd(REG_CTRL);
    chk("fallback master", 48'h23, 48'(d));
    wr(REG_CTRL, 32'h0000_0001);
    rd(REG_CTRL);
    chk("free mode", 48'h11, 48'(d));
    chk("released", 48'h0, 48'(shDevOe));
    n0 = arrN + lostN + foundN;
    pulses(2'h1, 18'h0_010F, 408);
    chk("ignored", 48'(n0), 48'(arrN + lostN + foundN));
    $display("test modes done");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== verif/ets_pulse_gen.sv
// Pulse source model for the time pulse and shared pulse lines
`timescale 1ns/100ps
`default_nettype none
module ets_pulse_gen (
  // Clock and control
  input wire logic clk,
  input wire logic [1:0] lineSel,
  input wire logic [17:0] gap,
  // Pulse lines
  output logic extPulse,
  output logic shDrv,
  output logic shOe
);
  logic [17:0] cnt = 18'h0_0000;
  always @(posedge clk) begin
    cnt <= (lineSel == 2'h0 || cnt >= gap) ? 18'h0_0000 : cnt + 18'h0_0001;
  end
  assign extPulse = lineSel[0] && cnt < 18'h0_0004;
  // Shared wire released between pulses so the pull-down wins
  assign shDrv = lineSel[1] && cnt < 18'h0_0004;
  assign shOe = shDrv;
endmodule
`default_nettype wire
